// ===== rtl/mrr_pkg.sv
// Shared constants, types and helper functions for the move/return/rotate execution block.
package mrr_pkg;
    localparam int unsigned MRR_IW = 14;
    localparam int unsigned MRR_DW = 8;
    localparam int unsigned MRR_AW = 7;
    localparam int unsigned MRR_PW = 13;
    localparam int unsigned MRR_FILE_DEPTH = 128;
    localparam int unsigned MRR_STACK_DEPTH = 8;
    localparam int unsigned MRR_SPW = 3;

    // Instruction encodings: a word matches when (word & mask) == value.
    localparam logic [13:0] MRR_COPY_MASK = 14'h3F00;
    localparam logic [13:0] MRR_COPY_VAL = 14'h0800;
    localparam logic [13:0] MRR_ROT_MASK = 14'h3F00;
    localparam logic [13:0] MRR_ROT_VAL = 14'h0D00;
    localparam logic [13:0] MRR_STORE_MASK = 14'h3F80;
    localparam logic [13:0] MRR_STORE_VAL = 14'h0080;
    localparam logic [13:0] MRR_IDLE_MASK = 14'h3F9F;
    localparam logic [13:0] MRR_IDLE_VAL = 14'h0000;
    localparam logic [13:0] MRR_IRET_MASK = 14'h3FFF;
    localparam logic [13:0] MRR_IRET_VAL = 14'h0009;
    localparam logic [13:0] MRR_LIT_MASK = 14'h3C00;
    localparam logic [13:0] MRR_LIT_VAL = 14'h3000;
    localparam logic [13:0] MRR_RETLIT_MASK = 14'h3C00;
    localparam logic [13:0] MRR_RETLIT_VAL = 14'h3400;

    // Field positions inside the instruction word and the data byte.
    localparam int unsigned MRR_DEST_BIT = 7;
    localparam int unsigned MRR_MSB_BIT = 7;

    // Reset values and increment steps.
    localparam logic [7:0] MRR_ACC_RST = 8'h00;
    localparam logic [12:0] MRR_PC_RST = 13'h0000;
    localparam logic MRR_ZERO_RST = 1'b0;
    localparam logic MRR_CARRY_RST = 1'b0;
    localparam logic MRR_GIE_RST = 1'b0;
    localparam logic [12:0] MRR_PC_STEP = 13'h0001;
    localparam logic [2:0] MRR_SP_STEP = 3'h1;

    typedef enum logic [2:0] {
        MRR_ST_IDLE = 3'h1,
        MRR_ST_READ = 3'h2,
        MRR_ST_FLUSH = 3'h4
    } mrr_state_t;

    typedef enum logic [3:0] {
        MRR_OP_COPY,
        MRR_OP_ROT,
        MRR_OP_STORE,
        MRR_OP_IDLE,
        MRR_OP_IRET,
        MRR_OP_LIT,
        MRR_OP_RETLIT,
        MRR_OP_BAD
    } mrr_op_t;

    function automatic mrr_op_t mrr_decode(input logic [13:0] w);
        mrr_op_t op;
        op = MRR_OP_BAD;
        if ((w & MRR_COPY_MASK) == MRR_COPY_VAL) begin
            op = MRR_OP_COPY;
        end else if ((w & MRR_ROT_MASK) == MRR_ROT_VAL) begin
            op = MRR_OP_ROT;
        end else if ((w & MRR_STORE_MASK) == MRR_STORE_VAL) begin
            op = MRR_OP_STORE;
        end else if ((w & MRR_IRET_MASK) == MRR_IRET_VAL) begin
            op = MRR_OP_IRET;
        end else if ((w & MRR_IDLE_MASK) == MRR_IDLE_VAL) begin
            op = MRR_OP_IDLE;
        end else if ((w & MRR_LIT_MASK) == MRR_LIT_VAL) begin
            op = MRR_OP_LIT;
        end else if ((w & MRR_RETLIT_MASK) == MRR_RETLIT_VAL) begin
            op = MRR_OP_RETLIT;
        end
        return op;
    endfunction

    function automatic logic [12:0] mrr_pc_inc(input logic [12:0] pc);
        return pc + MRR_PC_STEP;
    endfunction
endpackage

// ===== rtl/mrr_bus.sv
// Interfaces carrying file-register and stack traffic between the core and its stores.
`timescale 1ns/10ps
interface mrr_file_if;
    logic wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic [6:0] pk_addr;
    logic [7:0] pk_data;
    modport core (output wr_en, wr_addr, wr_data, rd_addr, pk_addr, input rd_data, pk_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_addr, pk_addr, output rd_data, pk_data);
endinterface

interface mrr_stack_if;
    logic push;
    logic pop;
    logic [12:0] push_data;
    logic [12:0] top;
    modport core (output push, pop, push_data, input top);
    modport stk (input push, pop, push_data, output top);
endinterface

// ===== rtl/mrr_file_mem.sv
// File register store: 128 bytes, one write port, two read ports with registered data.
`timescale 1ns/10ps
module mrr_file_mem
    import mrr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    mrr_file_if.mem fb
);
    typedef struct packed {
        logic [MRR_FILE_DEPTH-1:0][7:0] arr;
        logic [7:0] rd;
        logic [7:0] pk;
    } mrr_mem_t;

    mrr_mem_t s_reg;
    mrr_mem_t s_next;

    // Reads return the old byte when the same address is written in that cycle.
    always_comb begin
        s_next = s_reg;
        s_next.rd = s_reg.arr[fb.rd_addr];
        s_next.pk = s_reg.arr[fb.pk_addr];
        if (fb.wr_en) begin
            s_next.arr[fb.wr_addr] = fb.wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign fb.rd_data = s_reg.rd;
    assign fb.pk_data = s_reg.pk;
endmodule

// ===== rtl/mrr_stack.sv
// Eight-level circular return-address stack.
`timescale 1ns/10ps
module mrr_stack
    import mrr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    mrr_stack_if.stk sb
);
    typedef struct packed {
        logic [MRR_STACK_DEPTH-1:0][12:0] ent;
        logic [2:0] sp;
    } mrr_stk_t;

    mrr_stk_t s_reg;
    mrr_stk_t s_next;

    // The pointer wraps silently, so overflow overwrites the oldest entry.
    always_comb begin
        s_next = s_reg;
        if (sb.push) begin
            s_next.sp = s_reg.sp + MRR_SP_STEP;
            s_next.ent[s_next.sp] = sb.push_data;
        end else if (sb.pop) begin
            s_next.sp = s_reg.sp - MRR_SP_STEP;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sb.top = s_reg.ent[s_reg.sp];
endmodule

// ===== rtl/mrr_exec.sv
// Execution unit for the copy, literal, store, idle, return and rotate instructions.
`timescale 1ns/10ps
// What this block does
// - Copy with target 0 loads accumulator.
// - Copy with target 1 rewrites source register.
// - Copy sets zero flag from value.
// - Literal load fills accumulator, flags untouched.
// - Interrupt return pops head, sets irq allow.
// - Store writes accumulator to register, flags untouched.
// - Literal return loads accumulator, flags untouched.
// - Literal return pops stack head into counter.
// - Literal return takes two cycles, discards prefetch.
// - Rotate left through carry, carry only.
// - Rotate target selects accumulator or register.
module mrr_exec (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [mrr_pkg::MRR_IW-1:0] INSTR_IN,
    input wire logic INSTR_VALID_IN,
    output logic INSTR_READY_OUT,
    input wire logic PUSH_IN,
    input wire logic [mrr_pkg::MRR_PW-1:0] PUSH_ADDR_IN,
    output logic PUSH_READY_OUT,
    input wire logic FILE_LOAD_IN,
    input wire logic [mrr_pkg::MRR_AW-1:0] FILE_LOAD_ADDR_IN,
    input wire logic [mrr_pkg::MRR_DW-1:0] FILE_LOAD_DATA_IN,
    input wire logic [mrr_pkg::MRR_AW-1:0] FILE_PEEK_ADDR_IN,
    output logic [mrr_pkg::MRR_DW-1:0] FILE_PEEK_DATA_OUT,
    output logic [mrr_pkg::MRR_DW-1:0] ACC_OUT,
    output logic ZERO_FLAG_OUT,
    output logic CARRY_FLAG_OUT,
    output logic GLOBAL_IRQ_ALLOW_OUT,
    output logic [mrr_pkg::MRR_PW-1:0] PROGRAM_COUNTER_OUT,
    output logic DONE_OUT,
    output logic DISCARD_OUT,
    output logic ILLEGAL_OUT
);
    import mrr_pkg::*;

    typedef struct packed {
        mrr_state_t state;
        logic [7:0] acc;
        logic zero;
        logic carry;
        logic global_irq_allow;
        logic [12:0] pc;
        logic [6:0] addr;
        logic dest;
        logic rot;
        logic done;
        logic discard;
        logic illegal;
    } mrr_core_t;

    mrr_core_t s_reg;
    mrr_core_t s_next;
    mrr_op_t op;
    logic [7:0] val;
    logic [7:0] result;
    logic idle_now;

    mrr_file_if fbus();
    mrr_stack_if sbus();

    ////////////////////////////////////////////////////////////////////////////////
    // Stores.

    mrr_file_mem u_file (
        .clk(CLK_IN),
        .rst_n(RST_N_IN),
        .fb(fbus.mem)
    );

    mrr_stack u_stack (
        .clk(CLK_IN),
        .rst_n(RST_N_IN),
        .sb(sbus.stk)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Execution.

    assign idle_now = (s_reg.state == MRR_ST_IDLE);
    assign op = mrr_decode(INSTR_IN);
    assign val = fbus.rd_data;
    // Rotation feeds the old carry in at the bottom.
    assign result = s_reg.rot ? {val[6:0], s_reg.carry} : val;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.discard = 1'b0;
        s_next.illegal = 1'b0;
        fbus.wr_en = 1'b0;
        fbus.wr_addr = s_reg.addr;
        fbus.wr_data = s_reg.acc;
        fbus.rd_addr = s_reg.addr;
        fbus.pk_addr = FILE_PEEK_ADDR_IN;
        sbus.push = 1'b0;
        sbus.pop = 1'b0;
        sbus.push_data = PUSH_ADDR_IN;
        case (s_reg.state)
            MRR_ST_IDLE: begin
                if (INSTR_VALID_IN) begin
                    case (op)
                        MRR_OP_COPY, MRR_OP_ROT: begin
                            // The byte comes out of a registered store, so the
                            // write-back waits one clock for it.
                            s_next.addr = INSTR_IN[6:0];
                            s_next.dest = INSTR_IN[MRR_DEST_BIT];
                            s_next.rot = (op == MRR_OP_ROT);
                            fbus.rd_addr = INSTR_IN[6:0];
                            s_next.state = MRR_ST_READ;
                        end
                        MRR_OP_LIT: begin
                            // Upper bits are assumed zero and ignored.
                            s_next.acc = INSTR_IN[7:0];
                            s_next.pc = mrr_pc_inc(s_reg.pc);
                            s_next.done = 1'b1;
                        end
                        MRR_OP_STORE: begin
                            fbus.wr_en = 1'b1;
                            fbus.wr_addr = INSTR_IN[6:0];
                            fbus.wr_data = s_reg.acc;
                            s_next.pc = mrr_pc_inc(s_reg.pc);
                            s_next.done = 1'b1;
                        end
                        MRR_OP_IDLE: begin
                            s_next.pc = mrr_pc_inc(s_reg.pc);
                            s_next.done = 1'b1;
                        end
                        MRR_OP_IRET: begin
                            s_next.pc = sbus.top;
                            sbus.pop = 1'b1;
                            s_next.global_irq_allow = 1'b1;
                            s_next.state = MRR_ST_FLUSH;
                        end
                        MRR_OP_RETLIT: begin
                            s_next.acc = INSTR_IN[7:0];
                            s_next.pc = sbus.top;
                            sbus.pop = 1'b1;
                            s_next.state = MRR_ST_FLUSH;
                        end
                        default: begin
                            // Words outside this subset are skipped, not executed.
                            s_next.pc = mrr_pc_inc(s_reg.pc);
                            s_next.illegal = 1'b1;
                            s_next.done = 1'b1;
                        end
                    endcase
                end else if (PUSH_IN) begin
                    sbus.push = 1'b1;
                end
            end
            MRR_ST_READ: begin
                if (s_reg.rot) begin
                    s_next.carry = val[MRR_MSB_BIT];
                end else begin
                    s_next.zero = (val == 8'h00);
                end
                if (s_reg.dest) begin
                    fbus.wr_en = 1'b1;
                    fbus.wr_data = result;
                end else begin
                    s_next.acc = result;
                end
                s_next.pc = mrr_pc_inc(s_reg.pc);
                s_next.done = 1'b1;
                s_next.state = MRR_ST_IDLE;
            end
            MRR_ST_FLUSH: begin
                s_next.discard = 1'b1;
                s_next.done = 1'b1;
                s_next.state = MRR_ST_IDLE;
            end
            default: begin
                s_next.state = MRR_ST_IDLE;
            end
        endcase
        // Host preload shares the write port and yields to execution.
        if (!fbus.wr_en && FILE_LOAD_IN) begin
            fbus.wr_en = 1'b1;
            fbus.wr_addr = FILE_LOAD_ADDR_IN;
            fbus.wr_data = FILE_LOAD_DATA_IN;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            s_reg.state <= MRR_ST_IDLE;
            s_reg.acc <= MRR_ACC_RST;
            s_reg.zero <= MRR_ZERO_RST;
            s_reg.carry <= MRR_CARRY_RST;
            s_reg.global_irq_allow <= MRR_GIE_RST;
            s_reg.pc <= MRR_PC_RST;
            s_reg.addr <= 7'h00;
            s_reg.dest <= 1'b0;
            s_reg.rot <= 1'b0;
            s_reg.done <= 1'b0;
            s_reg.discard <= 1'b0;
            s_reg.illegal <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign INSTR_READY_OUT = idle_now;
    assign PUSH_READY_OUT = idle_now && !INSTR_VALID_IN;
    assign FILE_PEEK_DATA_OUT = fbus.pk_data;
    assign ACC_OUT = s_reg.acc;
    assign ZERO_FLAG_OUT = s_reg.zero;
    assign CARRY_FLAG_OUT = s_reg.carry;
    assign GLOBAL_IRQ_ALLOW_OUT = s_reg.global_irq_allow;
    assign PROGRAM_COUNTER_OUT = s_reg.pc;
    assign DONE_OUT = s_reg.done;
    assign DISCARD_OUT = s_reg.discard;
    assign ILLEGAL_OUT = s_reg.illegal;
endmodule

// ===== test/mrr_exec_chk.sv
// Port-level assertions for the move/return/rotate execution block.
`timescale 1ns/10ps
module mrr_exec_chk (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [mrr_pkg::MRR_IW-1:0] INSTR_IN,
    input wire logic INSTR_VALID_IN,
    input logic INSTR_READY_OUT,
    input logic [mrr_pkg::MRR_DW-1:0] ACC_OUT,
    input logic ZERO_FLAG_OUT,
    input logic CARRY_FLAG_OUT,
    input logic GLOBAL_IRQ_ALLOW_OUT,
    input logic [mrr_pkg::MRR_PW-1:0] PROGRAM_COUNTER_OUT,
    input logic DONE_OUT,
    input logic DISCARD_OUT
);
    import mrr_pkg::*;
    logic take;
    logic [7:0] lit_k;
    assign take = INSTR_VALID_IN && INSTR_READY_OUT;
    assign lit_k = INSTR_IN[7:0];
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    ////////////////////////////////////////////////////////////////////////////////
    // Two-cycle instructions keep the done pulse low for one cycle first.
    sequence s_late(c);
        !DONE_OUT ##1 (DONE_OUT && c);
    endsequence
    sequence s_ret_tail;
        !DONE_OUT ##1 (DONE_OUT && DISCARD_OUT);
    endsequence
    AST_LIT_LOAD: assert property (
        take && (INSTR_IN & MRR_LIT_MASK) == MRR_LIT_VAL |=> DONE_OUT && ACC_OUT == $past(lit_k)
        && $stable(ZERO_FLAG_OUT) && $stable(CARRY_FLAG_OUT)) else $error("literal load wrong");
    AST_RETLIT_ACC: assert property (
        take && (INSTR_IN & MRR_RETLIT_MASK) == MRR_RETLIT_VAL |=> ACC_OUT == $past(lit_k)
        && $stable(ZERO_FLAG_OUT) && $stable(CARRY_FLAG_OUT)) else $error("literal return wrong");
    AST_RET_TIMING: assert property (
        take && ((INSTR_IN & MRR_RETLIT_MASK) == MRR_RETLIT_VAL || INSTR_IN == MRR_IRET_VAL)
        |=> s_ret_tail) else $error("return timing wrong");
    AST_IRET_GIE: assert property (
        take && INSTR_IN == MRR_IRET_VAL |=> GLOBAL_IRQ_ALLOW_OUT && $stable(ACC_OUT)
        && $stable(ZERO_FLAG_OUT)) else $error("interrupt return wrong");
    AST_IDLE_STEP: assert property (
        take && (INSTR_IN & MRR_IDLE_MASK) == MRR_IDLE_VAL |=> DONE_OUT && !DISCARD_OUT
        && PROGRAM_COUNTER_OUT == $past(PROGRAM_COUNTER_OUT) + 13'h0001 && $stable(ACC_OUT))
        else $error("idle step wrong");
    AST_STORE_KEEP: assert property (
        take && (INSTR_IN & MRR_STORE_MASK) == MRR_STORE_VAL |=> DONE_OUT && $stable(ACC_OUT)
        && $stable(ZERO_FLAG_OUT) && $stable(CARRY_FLAG_OUT)) else $error("store changed state");
    AST_COPY_ZERO: assert property (
        take && (INSTR_IN & MRR_COPY_MASK) == MRR_COPY_VAL && !INSTR_IN[7]
        |=> s_late(ZERO_FLAG_OUT == (ACC_OUT == 8'h00))) else $error("copy zero flag wrong");
    AST_COPY_KEEP: assert property (
        take && (INSTR_IN & MRR_COPY_MASK) == MRR_COPY_VAL && INSTR_IN[7]
        |=> $stable(ACC_OUT) ##1 ($stable(ACC_OUT) && DONE_OUT)) else $error("copy hit acc");
    AST_ROT_CARRY_IN: assert property (
        take && (INSTR_IN & MRR_ROT_MASK) == MRR_ROT_VAL && !INSTR_IN[7]
        |=> s_late(ACC_OUT[0] == $past(CARRY_FLAG_OUT, 2) && $stable(ZERO_FLAG_OUT)))
        else $error("rotate result wrong");
    AST_DISCARD_DONE: assert property (
        DISCARD_OUT |-> DONE_OUT) else $error("discard without done");
endmodule
bind mrr_exec mrr_exec_chk i_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .INSTR_IN(INSTR_IN),
    .INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_READY_OUT(INSTR_READY_OUT), .ACC_OUT(ACC_OUT),
    .ZERO_FLAG_OUT(ZERO_FLAG_OUT), .CARRY_FLAG_OUT(CARRY_FLAG_OUT),
    .GLOBAL_IRQ_ALLOW_OUT(GLOBAL_IRQ_ALLOW_OUT), .PROGRAM_COUNTER_OUT(PROGRAM_COUNTER_OUT),
    .DONE_OUT(DONE_OUT), .DISCARD_OUT(DISCARD_OUT));

// ===== test/test_mrr_exec.sv
// Self-checking bench for the move/return/rotate execution block.
`timescale 1ns/10ps
module test_mrr_exec;
    import mrr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic valid = 1'b0;
    logic push = 1'b0;
    logic [12:0] push_addr = 13'h0000;
    logic load = 1'b0;
    logic [6:0] load_addr = 7'h00;
    logic [7:0] load_data = 8'h00;
    logic [6:0] peek_addr = 7'h00;
    logic [7:0] peek_data, acc, rd;
    logic [12:0] pc;
    logic ready, push_ready, zero, carry, global_irq_allow, done, discard, illegal, disc, ill;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc;
    mrr_exec i_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .INSTR_IN(instr), .INSTR_VALID_IN(valid),
        .INSTR_READY_OUT(ready), .PUSH_IN(push), .PUSH_ADDR_IN(push_addr),
        .PUSH_READY_OUT(push_ready), .FILE_LOAD_IN(load), .FILE_LOAD_ADDR_IN(load_addr),
        .FILE_LOAD_DATA_IN(load_data), .FILE_PEEK_ADDR_IN(peek_addr),
        .FILE_PEEK_DATA_OUT(peek_data), .ACC_OUT(acc), .ZERO_FLAG_OUT(zero),
        .CARRY_FLAG_OUT(carry), .GLOBAL_IRQ_ALLOW_OUT(global_irq_allow), .PROGRAM_COUNTER_OUT(pc),
        .DONE_OUT(done), .DISCARD_OUT(discard), .ILLEGAL_OUT(illegal));
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Inputs move on the falling edge so the design samples settled values.
    task run(input logic [13:0] w);
        @(negedge clk);
        instr = w;
        valid = 1'b1;
        @(posedge clk);
        cyc = 0;
        do begin
            @(negedge clk);
            valid = 1'b0;
            cyc++;
        end while (done !== 1'b1 && cyc < 8);
        disc = discard;
        ill = illegal;
    endtask
    task host(input logic ld, input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        load = ld;
        load_addr = a;
        load_data = d;
        peek_addr = a;
        @(negedge clk);
        load = 1'b0;
        rd = peek_data;
    endtask
    task push_ret(input logic [12:0] a);
        @(negedge clk);
        chk(16'({ready, push_ready}), 16'h0003);
        push = 1'b1;
        push_addr = a;
        @(negedge clk);
        push = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_literal;
        logic [7:0] ks [3] = '{8'h00, 8'hFF, 8'h5A};
        foreach (ks[i]) begin
            run(14'h3000 | {6'h00, ks[i]});
            chk(16'(acc), {8'h00, ks[i]});
            chk(16'({cyc[3:0], zero, carry}), 16'h0004);
        end
        $display("literal test done");
    endtask
    task t_copy;
        host(1'b1, 7'h03, 8'h00);
        host(1'b1, 7'h7F, 8'h80);
        run(14'h087F);
        chk(16'({acc, zero}), 16'h0100);
        run(14'h0803);
        chk(16'({acc, zero}), 16'h0001);
        run(14'h08FF);
        host(1'b0, 7'h7F, 8'h00);
        chk(16'({acc, zero}), 16'h0000);
        chk(16'(rd), 16'h0080);
        $display("copy test done");
    endtask
    task t_store;
        run(14'h0883);
        run(14'h30A5);
        run(14'h0090);
        host(1'b0, 7'h10, 8'h00);
        chk(16'(rd), 16'h00A5);
        chk(16'({cyc[3:0], zero, carry}), 16'h0006);
        $display("store test done");
    endtask
    task t_rotate;
        host(1'b1, 7'h05, 8'h81);
        run(14'h0D05);
        chk(16'({acc, zero, carry}), 16'h000B);
        run(14'h0D85);
        host(1'b0, 7'h05, 8'h00);
        chk(16'({rd, acc}), 16'h0302);
        run(14'h0D05);
        chk(16'({acc, zero, carry}), 16'h001E);
        $display("rotate test done");
    endtask
    task t_idle;
        logic [12:0] p;
        p = pc;
        run(14'h0000);
        chk(16'(pc), 16'(p + 13'h0001));
        chk(16'({acc, ill, cyc[3:0], disc}), 16'h01C2);
        // A word outside the subset is skipped like an idle word, but flagged.
        run(14'h0A00);
        chk(16'(pc), 16'(p + 13'h0002));
        chk(16'({ill, cyc[3:0], disc}), 16'h0022);
        $display("idle test done");
    endtask
    task t_returns;
        push_ret(13'h1234);
        push_ret(13'h0ABC);
        run(14'h343C);
        chk(16'({acc, zero, carry, global_irq_allow}), 16'h01E4);
        chk(16'(pc), 16'h0ABC);
        chk(16'({cyc[3:0], disc}), 16'h0005);
        run(14'h0009);
        chk(16'(pc), 16'h1234);
        chk(16'({acc, global_irq_allow}), 16'h0079);
        chk(16'({cyc[3:0], disc}), 16'h0005);
        $display("return test done");
    endtask
    task finish_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(16'({acc, zero, carry, global_irq_allow, ready}), 16'h0001);
        chk(16'(pc), 16'h0000);
        t_literal;
        t_copy;
        t_store;
        t_rotate;
        t_idle;
        t_returns;
        finish_test;
    end
    // The whole sequence needs under a hundred cycles; this leaves a wide margin.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test;
    end
endmodule
